// file: rtl/sam_pkg.sv
// shared constants of the reference alignment monitor
// assumes one 200 MHz converter clock and an 8-bit register port
package sam_pkg;

    // ------------------------------------------------------------
    // register port
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_IRQ_ENABLE    = 8'h20;
    localparam logic [7:0] OFS_IRQ_STATUS0   = 8'h24;
    localparam logic [7:0] OFS_IRQ_STATUS3   = 8'h27;
    localparam logic [7:0] OFS_IRQ_MUX       = 8'h28;
    localparam logic [7:0] OFS_IRQ_MUX2      = 8'h2b;
    localparam logic [7:0] OFS_IRQ_SUMMARY   = 8'h2c;
    localparam logic [7:0] OFS_EDGE_SKIP     = 8'h36;
    localparam logic [7:0] OFS_JITTER_WINDOW = 8'h39;
    localparam logic [7:0] OFS_ALIGN_MODE    = 8'h3a;
    localparam logic [7:0] OFS_ROTATION      = 8'h3b;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int BIT_EN_PLL_LOCK  = 0;
    localparam int BIT_EN_JITTER    = 1;
    localparam int BIT_MUX_JITTER   = 4;
    localparam int BIT_PLL_LOCK_PIN_SELECT = 0;
    localparam int BIT_SUMMARY      = 0;
    localparam int BIT_ONESHOT      = 1;
    localparam int BIT_ROT_DONE     = 4;
    localparam int BIT_LOGIC_EN     = 7;
    localparam int STAT_PLL_LOCK    = 0;
    localparam int STAT_JITTER      = 8;
    localparam int STAT_W           = 32;
    localparam int WINDOW_W         = 7;
    localparam int MODE_W           = 2;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_ROTATION  = 8'hb0;
    localparam logic [7:0] RST_EDGE_SKIP = 8'h00;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 5;
    localparam int ROT_TIME_NS   = 20;
    localparam int ROT_CYCLES    = (ROT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ROT_CNT_W     = 4;

    typedef enum logic [1:0] {
        SAM_MONITOR,
        SAM_SKIP,
        SAM_ROTATE
    } sam_state_t;

endpackage : sam_pkg

// file: rtl/sam_top.sv
// reference alignment monitor: edge skip, jitter window, one-shot rotation,
// interrupt latches with summary bit and two interrupt pins
// assumes sysref_in is asynchronous; pll_lock_event is a core_clk pulse
//
// Behaviour
// - enabled pll lock event goes to pin a when select is 0, pin b when 1
// - summary bit is the OR of all latched bits at 0x24 to 0x27
// - writing one to the summary bit clears all latched interrupt bits
// - pulse counting skips the programmed 8-bit number of rising edges first
// - a 7-bit jitter tolerance in converter clocks is held
// - monitor mode flags jitter and interrupts when an edge leaves the window
// - bit 1 of the alignment mode register enables one-shot rotation
// - one-shot aligns once on the first edge after the skipped ones then returns to monitor mode
// - read-only rotation complete flag reads one after reset
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/10ps
module sam_top
    import sam_pkg::*;
#(
    parameter int PHASE_W = 16
) (
    input  wire logic              core_clk,
    input  wire logic              arst_n,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [DATA_W-1:0] reg_rdata,
    input  wire logic              sysref_in,
    input  wire logic              pll_lock_event,
    input  wire logic [STAT_W-1:0] other_irq_events,
    output logic                   interrupt_pin_a_n,
    output logic                   interrupt_pin_b_n,
    output logic                   align_rotate
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [2:0]           sync_q;
    logic                 ref_level,         next_ref_level;
    logic [7:0]           irq_enable,        next_irq_enable;
    logic [7:0]           irq_mux,           next_irq_mux;
    logic [7:0]           irq_mux2,          next_irq_mux2;
    logic [STAT_W-1:0]    irq_latch,         next_irq_latch;
    logic [7:0]           ignored_edge_count, next_ignored_edge_count;
    logic [WINDOW_W-1:0]  jitter_tolerance_value, next_jitter_tolerance_value;
    logic [MODE_W-1:0]    alignment_mode_control, next_alignment_mode_control;
    logic [7:0]           rotation_control,  next_rotation_control;
    logic                 rotation_done,     next_rotation_done;
    sam_state_t           state,             next_state;
    logic [7:0]           skip_left,         next_skip_left;
    logic [ROT_CNT_W-1:0] rot_cnt,           next_rot_cnt;
    logic [PHASE_W-1:0]   phase,             next_phase;
    logic [PHASE_W-1:0]   period,            next_period;
    logic                 period_valid,      next_period_valid;
    logic [DATA_W-1:0]    next_reg_rdata;
    logic                 next_pin_a_n;
    logic                 next_pin_b_n;
    logic                 next_align_rotate;

    logic                 ref_rise;
    logic                 jitter_event;
    logic [PHASE_W-1:0]   deviation;
    logic [STAT_W-1:0]    new_events;
    logic                 pll_to_a;
    logic                 pll_to_b;
    logic                 jit_to_a;
    logic                 jit_to_b;

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function automatic logic wr_hit(input logic [ADDR_W-1:0] ofs);
        wr_hit = reg_wr && (reg_addr == ofs);
    endfunction : wr_hit

    function automatic logic [DATA_W-1:0] status_byte(input logic [1:0] idx);
        status_byte = irq_latch[idx*8 +: 8];
    endfunction : status_byte

    // ------------------------------------------------------------
    // reference edge detect
    // ------------------------------------------------------------
    always_comb begin
        next_ref_level = ref_level;
        ref_rise       = 1'b0;
        if (sync_q[1] == sync_q[2]) begin
            next_ref_level = sync_q[2];
            ref_rise       = sync_q[2] && !ref_level;
        end
    end

    // ------------------------------------------------------------
    // alignment control
    // ------------------------------------------------------------
    always_comb begin
        next_state                  = state;
        next_skip_left              = skip_left;
        next_rot_cnt                = rot_cnt;
        next_rotation_done          = rotation_done;
        next_period                 = period;
        next_period_valid           = period_valid;
        next_align_rotate           = 1'b0;
        next_alignment_mode_control = alignment_mode_control;
        jitter_event                = 1'b0;
        deviation                   = '0;
        next_phase                  = (&phase) ? phase : phase + 1'b1;
        if (ref_rise) begin
            next_phase = '0;
        end
        if (wr_hit(OFS_ALIGN_MODE)) begin
            next_alignment_mode_control = reg_wdata[MODE_W-1:0];
        end
        unique case (state)
            SAM_MONITOR: begin
                if (ref_rise) begin
                    if (!period_valid) begin
                        next_period       = phase;
                        next_period_valid = 1'b1;
                    end else begin
                        deviation = (phase > period) ? phase - period : period - phase;
                        // edge outside the tolerance window
                        jitter_event = (deviation > PHASE_W'(jitter_tolerance_value));
                    end
                end
                if (alignment_mode_control[BIT_ONESHOT]) begin
                    next_skip_left = ignored_edge_count;
                    next_state     = SAM_SKIP;
                end
            end
            SAM_SKIP: begin
                if (!alignment_mode_control[BIT_ONESHOT]) begin
                    next_state = SAM_MONITOR;
                end else if (ref_rise && rotation_control[BIT_LOGIC_EN]) begin
                    if (skip_left != 8'h00) begin
                        next_skip_left = skip_left - 8'h01;
                    end else begin
                        // single rotation, then back to monitor
                        next_align_rotate = 1'b1;
                        next_rotation_done = 1'b0;
                        next_rot_cnt = ROT_CNT_W'(ROT_CYCLES - 1);
                        next_period_valid = 1'b0;
                        next_alignment_mode_control[BIT_ONESHOT] = 1'b0;
                        next_state = SAM_ROTATE;
                    end
                end
            end
            SAM_ROTATE: begin
                if (rot_cnt == '0) begin
                    next_rotation_done = 1'b1;
                    next_state         = SAM_MONITOR;
                end else begin
                    next_rot_cnt = rot_cnt - 1'b1;
                end
            end
            default: begin
                next_state = SAM_MONITOR;
            end
        endcase
    end

    // ------------------------------------------------------------
    // control registers and interrupt latches
    // ------------------------------------------------------------
    always_comb begin
        next_irq_enable             = irq_enable;
        next_irq_mux                = irq_mux;
        next_irq_mux2               = irq_mux2;
        next_ignored_edge_count     = ignored_edge_count;
        next_jitter_tolerance_value = jitter_tolerance_value;
        next_rotation_control       = rotation_control;
        if (wr_hit(OFS_IRQ_ENABLE))    next_irq_enable = reg_wdata;
        if (wr_hit(OFS_IRQ_MUX))       next_irq_mux = reg_wdata;
        if (wr_hit(OFS_IRQ_MUX2))      next_irq_mux2 = reg_wdata;
        if (wr_hit(OFS_EDGE_SKIP))     next_ignored_edge_count = reg_wdata;
        if (wr_hit(OFS_JITTER_WINDOW)) next_jitter_tolerance_value = reg_wdata[WINDOW_W-1:0];
        if (wr_hit(OFS_ROTATION))      next_rotation_control = reg_wdata;
        new_events = other_irq_events;
        new_events[STAT_PLL_LOCK] = other_irq_events[STAT_PLL_LOCK] | pll_lock_event;
        new_events[STAT_JITTER]   = other_irq_events[STAT_JITTER] | jitter_event;
        next_irq_latch = irq_latch;
        if (wr_hit(OFS_IRQ_SUMMARY) && reg_wdata[BIT_SUMMARY]) begin
            next_irq_latch = '0;
        end
        // a new event wins over a clear in the same cycle
        next_irq_latch = next_irq_latch | new_events;
    end

    // ------------------------------------------------------------
    // interrupt pin routing
    // ------------------------------------------------------------
    always_comb begin
        pll_to_a = irq_enable[BIT_EN_PLL_LOCK] && irq_latch[STAT_PLL_LOCK]
                   && !irq_mux2[BIT_PLL_LOCK_PIN_SELECT];
        pll_to_b = irq_enable[BIT_EN_PLL_LOCK] && irq_latch[STAT_PLL_LOCK]
                   && irq_mux2[BIT_PLL_LOCK_PIN_SELECT];
        jit_to_a = irq_enable[BIT_EN_JITTER] && irq_latch[STAT_JITTER]
                   && !irq_mux[BIT_MUX_JITTER];
        jit_to_b = irq_enable[BIT_EN_JITTER] && irq_latch[STAT_JITTER]
                   && irq_mux[BIT_MUX_JITTER];
        next_pin_a_n = !(pll_to_a || jit_to_a);
        next_pin_b_n = !(pll_to_b || jit_to_b);
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    always_comb begin
        next_reg_rdata = '0;
        if (reg_rd) begin
            unique case (reg_addr)
                OFS_IRQ_ENABLE:    next_reg_rdata = irq_enable;
                OFS_IRQ_MUX:       next_reg_rdata = irq_mux;
                OFS_IRQ_MUX2:      next_reg_rdata = irq_mux2;
                OFS_IRQ_SUMMARY:   next_reg_rdata = {7'h00, |irq_latch};
                OFS_EDGE_SKIP:     next_reg_rdata = ignored_edge_count;
                OFS_JITTER_WINDOW: next_reg_rdata = {1'b0, jitter_tolerance_value};
                OFS_ALIGN_MODE: begin
                    next_reg_rdata = {6'h00, alignment_mode_control};
                    next_reg_rdata[BIT_ROT_DONE] = rotation_done;
                end
                OFS_ROTATION:      next_reg_rdata = rotation_control;
                default: begin
                    if (reg_addr >= OFS_IRQ_STATUS0 && reg_addr <= OFS_IRQ_STATUS3) begin
                        next_reg_rdata = status_byte(reg_addr[1:0]);
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sync_q                 <= 3'h0;
            ref_level              <= 1'b0;
        end else begin
            sync_q                 <= {sync_q[1:0], sysref_in};
            ref_level              <= next_ref_level;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            alignment_mode_control <= '0;
            rotation_done          <= 1'b1;
            state                  <= SAM_MONITOR;
            skip_left              <= 8'h00;
            rot_cnt                <= '0;
            phase                  <= '0;
            period                 <= '0;
            period_valid           <= 1'b0;
            align_rotate           <= 1'b0;
        end else begin
            alignment_mode_control <= next_alignment_mode_control;
            rotation_done          <= next_rotation_done;
            state                  <= next_state;
            skip_left              <= next_skip_left;
            rot_cnt                <= next_rot_cnt;
            phase                  <= next_phase;
            period                 <= next_period;
            period_valid           <= next_period_valid;
            align_rotate           <= next_align_rotate;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_enable             <= 8'h00;
            irq_mux                <= 8'h00;
            irq_mux2               <= 8'h00;
            irq_latch              <= '0;
            ignored_edge_count     <= RST_EDGE_SKIP;
            jitter_tolerance_value <= '0;
            rotation_control       <= RST_ROTATION;
        end else begin
            irq_enable             <= next_irq_enable;
            irq_mux                <= next_irq_mux;
            irq_mux2               <= next_irq_mux2;
            irq_latch              <= next_irq_latch;
            ignored_edge_count     <= next_ignored_edge_count;
            jitter_tolerance_value <= next_jitter_tolerance_value;
            rotation_control       <= next_rotation_control;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            interrupt_pin_a_n      <= 1'b1;
            interrupt_pin_b_n      <= 1'b1;
        end else begin
            interrupt_pin_a_n      <= next_pin_a_n;
            interrupt_pin_b_n      <= next_pin_b_n;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata              <= '0;
        end else begin
            reg_rdata              <= next_reg_rdata;
        end
    end

endmodule : sam_top

// file: testbench/sam_refgen_model.sv
// reference pulse generator in place of the external clock source
// assumes core_clk from the bench; line stays low while disabled
`timescale 1ns/10ps
module sam_refgen_model (
    input  wire logic       core_clk,
    input  wire logic       enable,
    input  wire logic [7:0] period,
    output logic            sysref_out = 1'b0
);
    logic [7:0] cnt = 8'h00;
    // ------------------------------------------------------------
    // pulse train, four cycles high per period
    // ------------------------------------------------------------
    always @(posedge core_clk) begin
        if (!enable) begin
            cnt        <= 8'h00;
            sysref_out <= 1'b0;
        end else begin
            cnt        <= (cnt + 8'h01 >= period) ? 8'h00 : cnt + 8'h01;
            sysref_out <= (cnt < 8'h04);
        end
    end
endmodule : sam_refgen_model

// file: testbench/sam_top_assertions.sv
// port checker for the alignment monitor
// assumes sam_top ports; register shadows are kept from bus writes
`timescale 1ns/10ps
module sam_top_assertions
    import sam_pkg::*;
(
    input wire logic              core_clk,
    input wire logic              arst_n,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic              sysref_in,
    input wire logic              pll_lock_event,
    input wire logic [STAT_W-1:0] other_irq_events,
    input wire logic              interrupt_pin_a_n,
    input wire logic              interrupt_pin_b_n,
    input wire logic              align_rotate
);
    logic       en_pll, sel_pll, armed, rot_seen;
    logic [6:0] win;
    logic [3:0] quiet;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    // ------------------------------------------------------------
    // shadows
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            {en_pll, sel_pll, armed, rot_seen, win, quiet} <= '0;
        end else begin
            quiet    <= sysref_in ? 4'h0 : ((quiet == 4'hf) ? quiet : quiet + 4'h1);
            rot_seen <= rot_seen | align_rotate;
            if (reg_wr && reg_addr == OFS_IRQ_ENABLE) en_pll <= reg_wdata[0];
            if (reg_wr && reg_addr == OFS_IRQ_MUX2) sel_pll <= reg_wdata[0];
            if (reg_wr && reg_addr == OFS_JITTER_WINDOW) win <= reg_wdata[6:0];
            if (reg_wr && reg_addr == OFS_ALIGN_MODE) armed <= reg_wdata[BIT_ONESHOT];
            else if (align_rotate) armed <= 1'b0;
        end
    end
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    property p_pll_a;
        pll_lock_event && en_pll && !sel_pll |-> ##[1:3] !interrupt_pin_a_n;
    endproperty
    property p_pll_b;
        pll_lock_event && en_pll && sel_pll |-> ##[1:3] !interrupt_pin_b_n;
    endproperty
    property p_clear;
        reg_wr && reg_addr == OFS_IRQ_SUMMARY && reg_wdata[0] && quiet == 4'hf
            && !pll_lock_event |-> ##2 (interrupt_pin_a_n && interrupt_pin_b_n);
    endproperty
    property p_win;
        reg_rd && reg_addr == OFS_JITTER_WINDOW |=> reg_rdata == {1'b0, win};
    endproperty
    property p_armed; align_rotate |-> armed; endproperty
    property p_single; align_rotate |=> !align_rotate [*4]; endproperty
    property p_busy;
        reg_rd && reg_addr == OFS_ALIGN_MODE && $past(align_rotate)
            |=> !reg_rdata[BIT_ROT_DONE] && !reg_rdata[BIT_ONESHOT];
    endproperty
    property p_rst_done;
        reg_rd && reg_addr == OFS_ALIGN_MODE && !rot_seen |=> reg_rdata[BIT_ROT_DONE];
    endproperty
    a_pll_a: assert property (p_pll_a) else $error("pin a not raised");
    a_pll_b: assert property (p_pll_b) else $error("pin b not raised");
    a_clear: assert property (p_clear) else $error("pins held after clear");
    a_win: assert property (p_win) else $error("window readback wrong");
    a_armed: assert property (p_armed) else $error("rotation while unarmed");
    a_single: assert property (p_single) else $error("second rotation");
    a_busy: assert property (p_busy) else $error("done during rotation");
    a_rst_done: assert property (p_rst_done) else $error("done low at reset");
    c_rot: cover property (align_rotate);
    c_pin_a: cover property (!interrupt_pin_a_n);
    c_pin_b: cover property (!interrupt_pin_b_n);
endmodule : sam_top_assertions

bind sam_top sam_top_assertions u_sam_top_assertions (
    .core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sysref_in(sysref_in),
    .pll_lock_event(pll_lock_event), .other_irq_events(other_irq_events),
    .interrupt_pin_a_n(interrupt_pin_a_n), .interrupt_pin_b_n(interrupt_pin_b_n),
    .align_rotate(align_rotate));

// file: testbench/tb.sv
// self-checking bench for the alignment monitor
// assumes sam_top and the reference generator model
`timescale 1ns/10ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
    import sam_pkg::*;
    logic              core_clk, arst_n, reg_wr, reg_rd, pll_lock_event, ref_en;
    logic [7:0]        reg_addr, reg_wdata, ref_period, reg_rdata;
    logic [STAT_W-1:0] other_irq_events;
    logic              sysref_in, pin_a_n, pin_b_n, align_rotate;
    int                error_cnt = 0, num_checks = 0, edges = 0, aligns = 0;
    logic [7:0]        ra [6] = '{OFS_ALIGN_MODE, OFS_ROTATION, OFS_EDGE_SKIP,
                                  OFS_JITTER_WINDOW, OFS_IRQ_SUMMARY, 8'h50};
    logic [7:0]        rv [6] = '{8'h10, RST_ROTATION, 8'h00, 8'h00, 8'h00, 8'h00};

    sam_top u_sam_top (.core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .sysref_in(sysref_in), .pll_lock_event(pll_lock_event),
        .other_irq_events(other_irq_events), .interrupt_pin_a_n(pin_a_n),
        .interrupt_pin_b_n(pin_b_n), .align_rotate(align_rotate));
    sam_refgen_model u_sam_refgen_model (.core_clk(core_clk), .enable(ref_en),
        .period(ref_period), .sysref_out(sysref_in));

    // ------------------------------------------------------------
    // clock, counters, bus tasks
    // ------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    always @(posedge sysref_in) edges++;
    always @(posedge core_clk) if (align_rotate === 1'b1) aligns++;

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 `CHK(reg_rdata, e)
    endtask : rd
    task automatic finish_test;
        $display("checks=%0d errors=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : finish_test

    initial begin
        #100000;
        error_cnt++;
        finish_test();
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        {arst_n, reg_wr, reg_rd, pll_lock_event, ref_en, reg_addr, reg_wdata} = '0;
        other_irq_events = '0;
        ref_period = 8'd40;
        repeat (5) @(posedge core_clk);
        arst_n <= 1'b1;
        foreach (ra[i]) rd(ra[i], rv[i]);
        wr(OFS_ROTATION, 8'hc0);
        rd(OFS_ROTATION, 8'hc0);
        wr(OFS_JITTER_WINDOW, 8'hff);
        rd(OFS_JITTER_WINDOW, 8'h7f);
        wr(OFS_ALIGN_MODE, 8'h11);
        rd(OFS_ALIGN_MODE, 8'h11);
        wr(OFS_ALIGN_MODE, 8'h00);
        $display("test registers done");
        wr(OFS_IRQ_ENABLE, 8'h01);
        for (int s = 0; s < 2; s++) begin
            wr(OFS_IRQ_MUX2, s[7:0]);
            pll_lock_event <= 1'b1;
            @(posedge core_clk);
            pll_lock_event <= 1'b0;
            repeat (3) @(posedge core_clk);
            #1 `CHK({pin_a_n, pin_b_n}, s ? 2'b10 : 2'b01)
            rd(OFS_IRQ_SUMMARY, 8'h01);
            wr(OFS_IRQ_SUMMARY, 8'h01);
            rd(OFS_IRQ_STATUS0, 8'h00);
            `CHK({pin_a_n, pin_b_n}, 2'b11)
        end
        @(posedge core_clk);
        other_irq_events <= 32'h8000_0000;
        @(posedge core_clk);
        other_irq_events <= '0;
        rd(OFS_IRQ_STATUS3, 8'h80);
        rd(OFS_IRQ_SUMMARY, 8'h01);
        wr(OFS_IRQ_SUMMARY, 8'h01);
        rd(OFS_IRQ_SUMMARY, 8'h00);
        $display("test interrupts done");
        wr(OFS_EDGE_SKIP, 8'h03);
        wr(OFS_ALIGN_MODE, 8'h02);
        edges  = 0;
        ref_en <= 1'b1;
        while (align_rotate !== 1'b1) begin
            @(posedge core_clk);
            #1;
        end
        `CHK(edges, 4)
        rd(OFS_ALIGN_MODE, 8'h00);
        repeat (120) @(posedge core_clk);
        #1 `CHK(aligns, 1)
        rd(OFS_ALIGN_MODE, 8'h10);
        $display("test alignment done");
        wr(OFS_IRQ_ENABLE, 8'h02);
        wr(OFS_JITTER_WINDOW, 8'h03);
        repeat (160) @(posedge core_clk);
        rd(OFS_IRQ_STATUS0 + 8'h01, 8'h00);
        ref_period <= 8'd42;
        repeat (130) @(posedge core_clk);
        rd(OFS_IRQ_STATUS0 + 8'h01, 8'h00);
        ref_period <= 8'd52;
        repeat (110) @(posedge core_clk);
        rd(OFS_IRQ_STATUS0 + 8'h01, 8'h01);
        `CHK(pin_a_n, 1'b0)
        wr(OFS_IRQ_MUX, 8'h10);
        rd(OFS_IRQ_MUX, 8'h10);
        `CHK({pin_a_n, pin_b_n}, 2'b10)
        $display("test jitter done");
        finish_test();
    end
endmodule : tb
